// File: logic/ani_align_insert.sv
// link transmitter that inserts align primitives and deletes received align and notify primitives
`timescale 1ns/100ps
`default_nettype none
`include "ani_align_regs.svh"

module ani_align_insert
    import ani_pkg::*;
#(
    parameter int FIFO_DEPTH = `ANI_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // link dword clock pin, sampled here
    input wire logic linkClk,
    // rates and modes
    input wire ani_pkg::ani_rate_t linkRate,
    input wire ani_pkg::ani_rate_t connRate,
    input wire logic stpToTarget,
    input wire logic bridgeMode,
    // connection events, one-cycle pulses
    input wire logic rmStart,
    input wire logic rmStop,
    input wire logic switchToOrig,
    input wire logic switchToFwd,
    // incoming dword stream
    input wire logic inValid,
    output logic inReady,
    input wire logic [`ANI_DWORD_W-1:0] inData,
    input wire logic inPrim,
    // outgoing dword slots
    output logic txValid,
    output logic txPrim,
    output logic [1:0] txAlignSel,
    output logic [`ANI_DWORD_W-1:0] txData,
    output logic originating,
    output logic rmActive
);
    import ani_pkg::*;

    if (FIFO_DEPTH < 4) begin : gDepthCheck
        $error("buffer must hold the dwords arriving during a pair");
    end

    // link clock synchroniser and edge finder
    logic lcS1_q, lcS2_q, lcS3_q;
    logic slot;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lcS1_q <= 1'b0;
            lcS2_q <= 1'b0;
            lcS3_q <= 1'b0;
        end else begin
            lcS1_q <= linkClk;
            lcS2_q <= lcS1_q;
            lcS3_q <= lcS2_q;
        end
    end

    assign slot = lcS2_q & ~lcS3_q;

    logic ffInValid, ffInReady, ffOutValid, popFifo;
    logic [`ANI_DWORD_W-1:0] ffOutData;

    assign ffInValid = inValid & ~inPrim;
    assign inReady = ffInReady | inPrim;

    ani_dword_fifo #(
        .WIDTH(`ANI_DWORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .wrValid(ffInValid),
        .wrReady(ffInReady),
        .wrData(inData),
        .rdValid(ffOutValid),
        .rdReady(popFifo),
        .rdData(ffOutData)
    );

    logic orig_q, orig_d, fwdAfter_q, fwdAfter_d;
    logic rmAct_q, rmAct_d;
    logic [1:0] rmRatio_q, rmRatio_d, rmPend_q, rmPend_d;
    logic [6:0] tolCnt_q, tolCnt_d;
    logic tolPend_q, tolPend_d, swPend_q, swPend_d;
    logic [7:0] thrCnt_q, thrCnt_d;
    logic [1:0] thrPend_q, thrPend_d, rot_q, rot_d;
    logic anyPend, sendPrim, tolOn, thrOn, underflow;
    logic [1:0] ratioNow;

    // rate matching ratio from link and connection rates
    // 3,0 link at 1,5 connection owes one primitive per dword
    always_comb begin
        ratioNow = `ANI_RM_NONE;
        if (linkRate == ANI_RATE_3G0 && connRate == ANI_RATE_1G5) begin
            ratioNow = `ANI_RM_HALF;
        end else if (linkRate == ANI_RATE_6G0) begin
            if (connRate == ANI_RATE_3G0) begin
                ratioNow = `ANI_RM_HALF;
            end else if (connRate == ANI_RATE_1G5) begin
                ratioNow = `ANI_RM_QUARTER;
            end
        end
    end

    assign anyPend = tolPend_q | swPend_q | (thrPend_q != 2'h0) |
        (rmPend_q != 2'h0);
    // forwarding underflow always yields a primitive
    assign underflow = slot & ~anyPend & ~ffOutValid;
    assign sendPrim = slot & (anyPend | ~ffOutValid);
    assign popFifo = slot & ~anyPend & ffOutValid;
    // tolerance only while originating and not bridging
    assign tolOn = orig_q & ~bridgeMode;
    assign thrOn = (orig_q & stpToTarget) | bridgeMode;

    always_comb begin
        orig_d = orig_q;
        fwdAfter_d = fwdAfter_q;
        rmAct_d = rmAct_q;
        rmRatio_d = rmRatio_q;
        rmPend_d = rmPend_q;
        tolCnt_d = tolCnt_q;
        tolPend_d = tolPend_q;
        swPend_d = swPend_q;
        thrCnt_d = thrCnt_q;
        thrPend_d = thrPend_q;
        rot_d = rot_q;
        // rotate variants on every primitive sent
        if (sendPrim) begin
            rot_d = rot_q + 2'h1;
        end
        // one primitive retires one source, tolerance first
        if (sendPrim) begin
            if (tolPend_q) begin
                tolPend_d = 1'b0;
                tolCnt_d = 7'h00;
            end else if (swPend_q) begin
                swPend_d = 1'b0;
                tolCnt_d = 7'h00;
                // primitive goes out before forwarding resumes
                if (fwdAfter_q) begin
                    orig_d = 1'b0;
                    fwdAfter_d = 1'b0;
                end
            end else if (thrPend_q != 2'h0) begin
                thrPend_d = thrPend_q - 2'h1;
            end else if (rmPend_q != 2'h0) begin
                rmPend_d = rmPend_q - 2'h1;
            end else begin
                tolCnt_d = 7'h00;
            end
        end
        // tolerance window counted on originated slots
        if (!tolOn) begin
            tolCnt_d = 7'h00;
            tolPend_d = 1'b0;
        end else if (slot && !(sendPrim && (tolPend_q || !anyPend))) begin
            tolCnt_d = tolCnt_q + 7'h01;
            if (tolCnt_q == `ANI_TOL_REQ) begin
                tolPend_d = 1'b1;
            end
        end
        // throttling pair after a run of data dwords
        if (!thrOn) begin
            thrCnt_d = 8'h00;
            thrPend_d = 2'h0;
        end else if (popFifo) begin
            if (thrCnt_q == `ANI_THR_SPAN - 8'h01) begin
                thrCnt_d = 8'h00;
                thrPend_d = `ANI_THR_BURST;
            end else begin
                thrCnt_d = thrCnt_q + 8'h01;
            end
        end else if (underflow && bridgeMode) begin
            // empty buffer: this primitive plus one more back to back
            thrCnt_d = 8'h00;
            thrPend_d = `ANI_THR_BURST - 2'h1;
        end
        // owed primitives per originated data dword
        if (popFifo && orig_q && rmAct_q) begin
            rmPend_d = rmRatio_q;
        end
        // latch the connection rate at connection start
        // stop clears what is still owed
        if (rmStart) begin
            rmAct_d = 1'b1;
            rmRatio_d = ratioNow;
        end else if (rmStop) begin
            rmAct_d = 1'b0;
            rmPend_d = 2'h0;
        end
        // a switch queues one primitive; a new request wins
        if (switchToOrig) begin
            orig_d = 1'b1;
            fwdAfter_d = 1'b0;
            swPend_d = 1'b1;
        end else if (switchToFwd) begin
            fwdAfter_d = 1'b1;
            swPend_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            orig_q <= 1'b1;
            fwdAfter_q <= 1'b0;
            rmAct_q <= 1'b0;
            rmRatio_q <= `ANI_RM_NONE;
            rmPend_q <= 2'h0;
            tolCnt_q <= 7'h00;
            tolPend_q <= 1'b0;
            swPend_q <= 1'b0;
            thrCnt_q <= 8'h00;
            thrPend_q <= 2'h0;
            rot_q <= 2'h0;
        end else begin
            orig_q <= orig_d;
            fwdAfter_q <= fwdAfter_d;
            rmAct_q <= rmAct_d;
            rmRatio_q <= rmRatio_d;
            rmPend_q <= rmPend_d;
            tolCnt_q <= tolCnt_d;
            tolPend_q <= tolPend_d;
            swPend_q <= swPend_d;
            thrCnt_q <= thrCnt_d;
            thrPend_q <= thrPend_d;
            rot_q <= rot_d;
        end
    end

    // registered outputs; only aligns sent, so no notify repeats
    logic txValid_q, txPrim_q, txRm_q, txRm_d;
    logic [1:0] txSel_q, txSel_d;
    logic [`ANI_DWORD_W-1:0] txData_q, txData_d;

    always_comb begin
        txSel_d = sendPrim ? rot_q : txSel_q;
        txData_d = popFifo ? ffOutData : '0;
        txRm_d = popFifo & orig_q & rmAct_q & (rmRatio_q != `ANI_RM_NONE);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txValid_q <= 1'b0;
            txPrim_q <= 1'b0;
            txRm_q <= 1'b0;
            txSel_q <= 2'h0;
            txData_q <= '0;
        end else begin
            txValid_q <= slot;
            txPrim_q <= sendPrim;
            txRm_q <= txRm_d;
            txSel_q <= txSel_d;
            txData_q <= txData_d;
        end
    end

    assign txValid = txValid_q;
    assign txPrim = txPrim_q;
    assign txAlignSel = txSel_q;
    assign txData = txData_q;
    assign originating = orig_q;
    assign rmActive = rmAct_q;

    // helper state for the checks below
    logic lastRm_q;
    logic [1:0] prevSel_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lastRm_q <= 1'b0;
            prevSel_q <= 2'h3;
        end else if (txValid_q) begin
            lastRm_q <= txRm_q;
            if (txPrim_q) begin
                prevSel_q <= txSel_q;
            end
        end
    end

    dropPrim_a: assert property (@(posedge clock) disable iff (!rst_n)
        inValid && inPrim |-> inReady && !ffInValid)
        else $error("received primitive reached the buffer");
    underflowIns_a: assert property (@(posedge clock) disable iff (!rst_n)
        underflow |=> txValid && txPrim && txData == '0)
        else $error("underflow slot did not carry a primitive");
    rmAlternate_a: assert property (@(posedge clock) disable iff (!rst_n)
        txValid_q && txRm_q |-> !lastRm_q)
        else $error("two rate matched data dwords back to back");
    rmBegin_a: assert property (@(posedge clock) disable iff (!rst_n)
        rmStart |=> rmActive && rmRatio_q == $past(ratioNow))
        else $error("rate matching did not start with latched ratio");
    rmEnd_a: assert property (@(posedge clock) disable iff (!rst_n)
        rmStop && !rmStart |=> !rmActive && rmPend_q == 2'h0)
        else $error("rate matching kept running after stop");
    tolGap_a: assert property (@(posedge clock) disable iff (!rst_n)
        tolOn |-> tolCnt_q < `ANI_TOL_SPAN)
        else $error("tolerance window exceeded");
    switchIns_a: assert property (@(posedge clock) disable iff (!rst_n)
        switchToOrig |-> ##[1:60] (txValid && txPrim))
        else $error("no primitive after switching to originating");
    fwdSwitch_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(originating) |-> txValid && txPrim)
        else $error("forwarding resumed without a primitive");
    rotation_a: assert property (@(posedge clock) disable iff (!rst_n)
        txValid && txPrim |-> txAlignSel == prevSel_q + 2'h1)
        else $error("align variant out of rotation");
    thrBurst_a: assert property (@(posedge clock) disable iff (!rst_n)
        popFifo && thrOn && thrCnt_q == `ANI_THR_SPAN - 8'h01
        |=> thrPend_q == `ANI_THR_BURST)
        else $error("throttle pair not queued after data run");
endmodule : ani_align_insert

`default_nettype wire

// File: inc/ani_align_regs.svh
// constants for align and notify insertion
`ifndef ANI_ALIGN_REGS_SVH
`define ANI_ALIGN_REGS_SVH

// one tolerance primitive within every 64 dwords while originating and not bridging
`define ANI_TOL_SPAN 7'h40
// request point leaves room for the primitive to be queued and sent
`define ANI_TOL_REQ 7'h3E
// throttling: two primitives after 254 non-primitive dwords
`define ANI_THR_SPAN 8'hFE
`define ANI_THR_BURST 2'h2
// rate matching primitives owed per originated data dword
`define ANI_RM_NONE 2'h0
`define ANI_RM_HALF 2'h1
`define ANI_RM_QUARTER 2'h3
// dword width and forwarding buffer depth
`define ANI_DWORD_W 32
`define ANI_FIFO_DEPTH 16

`endif

// File: inc/ani_pkg.sv
// types shared by the align and notify insertion block
package ani_pkg;
    typedef enum logic [1:0] {
        ANI_RATE_1G5,
        ANI_RATE_3G0,
        ANI_RATE_6G0
    } ani_rate_t;
endpackage : ani_pkg

// File: logic/ani_dword_fifo.sv
// dword buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module ani_dword_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // fill side
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [WIDTH-1:0] wrData,
    // drain side
    output logic rdValid,
    input wire logic rdReady,
    output logic [WIDTH-1:0] rdData
);
    localparam int AW = $clog2(DEPTH);

    // refused at elaboration: pointer wrap needs a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gParamCheck
        $error("fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic push, pop;

    // full when pointers differ only in the wrap bit
    assign wrReady = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
    assign rdValid = wrPtr_q != rdPtr_q;
    assign rdData = mem[rdPtr_q[AW-1:0]];
    assign push = wrValid & wrReady;
    assign pop = rdReady & rdValid;

    always_comb begin
        wrPtr_d = wrPtr_q + {{AW{1'b0}}, push};
        rdPtr_d = rdPtr_q + {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
        end
    end

    // storage needs no reset; only written entries are ever read
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= wrData;
        end
    end
endmodule : ani_dword_fifo

`default_nettype wire

// File: bench/ani_link_partner.sv
// far-side phy model: link dword clock source and slot receiver
`timescale 1ns/100ps
`default_nettype none

module ani_link_partner (
    // link clock made by the far side
    output logic linkClk,
    // receiving side
    input wire logic clock,
    input wire logic rst_n,
    input wire logic txValid,
    input wire logic txPrim,
    input wire logic clearMax,
    output var int maxRun
);
    int run;

    // slots paced at link rate
    // a serial link's dword clock runs free, unrelated in phase to clock
    initial begin
        linkClk = 1'b0;
        #3.3;
        forever #16 linkClk = ~linkClk;
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            run = 0;
            maxRun = 0;
        end else begin
            if (clearMax) begin
                maxRun = 0;
            end
            if (txValid && txPrim) begin
                run = 0;
            end else if (txValid) begin
                run++;
                if (run > maxRun) begin
                    maxRun = run;
                end
            end
        end
    end
endmodule : ani_link_partner

`default_nettype wire

// File: bench/tb_align_notify_insertion.sv
// self-checking bench for the align and notify insertion block
`timescale 1ns/100ps
`default_nettype none
`include "ani_align_regs.svh"

module tb_align_notify_insertion;
    import ani_pkg::*;
    logic clock, rst_n, stpToTarget, bridgeMode, rmStart, rmStop;
    logic switchToOrig, switchToFwd, inValid, inPrim, feed, clearMax;
    logic inReady, txValid, txPrim, originating, rmActive;
    wire logic linkClk;
    ani_rate_t linkRate, connRate;
    logic [1:0] txAlignSel, expSel;
    logic [31:0] inData, txData, nextIn, expData;
    int seq, maxRun, miscompares, comparisons;

    ani_align_insert #(.FIFO_DEPTH(`ANI_FIFO_DEPTH)) dut (
        .clock(clock), .rst_n(rst_n), .linkClk(linkClk),
        .linkRate(linkRate), .connRate(connRate),
        .stpToTarget(stpToTarget), .bridgeMode(bridgeMode),
        .rmStart(rmStart), .rmStop(rmStop),
        .switchToOrig(switchToOrig), .switchToFwd(switchToFwd),
        .inValid(inValid), .inReady(inReady), .inData(inData),
        .inPrim(inPrim), .txValid(txValid), .txPrim(txPrim),
        .txAlignSel(txAlignSel), .txData(txData),
        .originating(originating), .rmActive(rmActive));

    ani_link_partner farEnd (.linkClk(linkClk), .clock(clock),
        .rst_n(rst_n), .txValid(txValid), .txPrim(txPrim),
        .clearMax(clearMax), .maxRun(maxRun));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic checkBit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : checkBit

    task automatic checkWord(input string what, input logic [31:0] e,
                             input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : checkWord

    task automatic complete_run;
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick

    // bounded wait for the next outgoing slot, left just after its edge
    task automatic waitSlot;
        int n;
        n = 0;
        tick();
        while (txValid !== 1'b1) begin
            n++;
            if (n > 40) begin
                miscompares++;
                $display("mismatch slot wait expected 1 seen 0");
                complete_run();
            end
            tick();
        end
    endtask : waitSlot

    task automatic measure(input int n);
        clearMax = 1'b1;
        tick();
        clearMax = 1'b0;
        repeat (n) waitSlot();
    endtask : measure

    // source: every fifth dword is a primitive that must vanish
    always @(posedge clock) begin
        if (inValid === 1'b1 && inReady === 1'b1) begin
            seq++;
            nextIn = nextIn + (inPrim ? 32'h0 : 32'h1);
        end
        #1;
        inValid = feed;
        inPrim = (seq % 5 == 4);
        inData = inPrim ? 32'hFFFF_FFFF : nextIn;
    end

    // sink: data in order, aligns in rotation
    always @(posedge clock) begin
        if (rst_n && txValid) begin
            if (txPrim) begin
                checkWord("align variant", {30'h0, expSel}, {30'h0, txAlignSel});
                expSel <= expSel + 2'h1;
            end else begin
                checkWord("forwarded dword", expData, txData);
                expData <= expData + 32'h1;
            end
        end
    end

    task automatic resetState;
        checkBit("reset txValid", 1'b0, txValid);
        checkBit("reset originating", 1'b1, originating);
        checkBit("reset rmActive", 1'b0, rmActive);
        checkBit("reset inReady", 1'b1, inReady);
    endtask : resetState

    task automatic idlePrims;
        repeat (6) begin
            waitSlot();
            checkBit("underflow primitive", 1'b1, txPrim);
        end
    endtask : idlePrims

    task automatic tolerance;
        feed = 1'b1;
        measure(200);
        checkBit("tolerance run", 1'b1, maxRun > 1 && maxRun <= 63);
    endtask : tolerance

    task automatic rateMatch;
        linkRate = ANI_RATE_3G0;
        connRate = ANI_RATE_1G5;
        rmStart = 1'b1;
        tick();
        rmStart = 1'b0;
        checkBit("rate match on", 1'b1, rmActive);
        repeat (4) waitSlot();
        measure(100);
        checkWord("rate match run", 32'h1, maxRun);
        rmStop = 1'b1;
        tick();
        rmStop = 1'b0;
        checkBit("rate match off", 1'b0, rmActive);
        measure(100);
        checkBit("run after stop", 1'b1, maxRun > 1);
    endtask : rateMatch

    task automatic switching;
        int n;
        switchToFwd = 1'b1;
        tick();
        switchToFwd = 1'b0;
        waitSlot();
        checkBit("primitive before forwarding", 1'b1, txPrim);
        // a pending tolerance primitive may go first and delay the switch
        n = 0;
        while (originating !== 1'b0 && n < 12) begin
            n++;
            tick();
        end
        checkBit("forwarding mode", 1'b0, originating);
        measure(150);
        checkBit("no counted insertion", 1'b1, maxRun > 63);
        switchToOrig = 1'b1;
        tick();
        switchToOrig = 1'b0;
        checkBit("originating mode", 1'b1, originating);
        // the long forwarding run must end at the switch primitive first
        repeat (2) waitSlot();
        measure(150);
        checkBit("tolerance after switch", 1'b1, maxRun <= 63);
    endtask : switching

    task automatic bridge;
        int n;
        bridgeMode = 1'b1;
        stpToTarget = 1'b1;
        // the run begun before bridging only ends at the first pair
        repeat (260) waitSlot();
        measure(600);
        checkWord("throttle run", 32'hFE, maxRun);
        n = 0;
        // stalled input is data; wait past any slot that just popped
        while ((inPrim !== 1'b0 || txValid !== 1'b0) && n < 10) begin
            n++;
            tick();
        end
        checkBit("full buffer refuses", 1'b0, inReady);
        feed = 1'b0;
        repeat (20) waitSlot();
        waitSlot();
        checkBit("drained primitive", 1'b1, txPrim);
    endtask : bridge

    initial begin
        rst_n = 1'b0;
        linkRate = ANI_RATE_1G5;
        connRate = ANI_RATE_1G5;
        stpToTarget = 1'b0;
        bridgeMode = 1'b0;
        rmStart = 1'b0;
        rmStop = 1'b0;
        switchToOrig = 1'b0;
        switchToFwd = 1'b0;
        feed = 1'b0;
        clearMax = 1'b0;
        inValid = 1'b0;
        inPrim = 1'b0;
        inData = 32'h0;
        miscompares = 0;
        comparisons = 0;
        seq = 0;
        nextIn = 32'h1000;
        expData = 32'h1000;
        expSel = 2'h0;
        repeat (5) tick();
        resetState();
        rst_n = 1'b1;
        idlePrims();
        tolerance();
        rateMatch();
        switching();
        bridge();
        complete_run();
    end
endmodule : tb_align_notify_insertion

`default_nettype wire
